//--- rtl/sync_burst_sram.sv
// Notes on behaviour
// - all bus pins are sampled on the rising clock edge
// - output enable and sleep act without the clock
// - either address strobe loads a new address and starts a burst
// - later burst addresses come from the counter, stepped when advance is low
// - the burst counter is two bits and covers the two low address bits
// - order select low gives linear, high gives interleaved counting
// - a new address may be loaded in every cycle
// - flow-through mode sends read data around the output register
// - pipeline mode adds one rising-edge output register
// - in pipeline mode deselect passes one stage fewer than a read; in flow-through both pass one stage
// - outputs start turning off once deselect is sampled
// - byte write plus lane enables writes only the chosen lanes
// - global write low writes every lane
// - sleep high stops activity and keeps the array contents
// - selected only with enable one low, enable two high and enable three (aux) low
// - advance high holds the burst address
// - data pins driven only while output enable is low
// - each lane enable gates its own lane
// - two low address pins also preset the burst counter base
// - writes are timed internally from the sampled edge
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
module sync_burst_sram
  import sram_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int LN = LANES,
  parameter int LW = LANE_W
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic chip_sel_n_i,
  input wire logic chip_sel_hi_i,
  input wire logic chip_sel_aux_n_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic burst_step_n_i,
  input wire logic lane_write_en_n_i,
  input wire logic all_lane_write_n_i,
  input wire logic [LN-1:0] lane_sel_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [LN*LW-1:0] dq_i,
  output logic [LN*LW-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic out_en_n_i,
  input wire logic sleep_req_i,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  logic [1:0] ctrl_q;
  logic [AW-1:2] hi_q;
  logic [BURST_W-1:0] base_q, cnt_q, cur_cnt, acc_base, acc_cnt, acc_low;
  logic [AW-1:0] acc_addr;
  logic active_q, rd1_q, drive_q, sleep_q;
  logic [LN-1:0] lane_we, mem_we;
  logic [LN*LW-1:0] rdata, pipe_q;
  logic sel, awake, strobe_p, strobe_c, load, wr_any, desel, cont, step, rd, wr;
  logic flowthru, drive_d;
  op_type op;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_got_q, w_got_q;

  // ************************************************************
  // command decode
  // ************************************************************
  assign flowthru = ~ctrl_q[CTRL_FLOW_BIT];
  assign sel = ~chip_sel_n_i & chip_sel_hi_i & ~chip_sel_aux_n_i;
  assign awake = ~sleep_req_i;
  // processor strobe is ignored while the first enable is high
  assign strobe_p = ~proc_addr_strobe_n_i & ~chip_sel_n_i;
  assign strobe_c = ~ctrl_addr_strobe_n_i;
  assign load = awake & (strobe_p | strobe_c);
  assign wr_any = ~all_lane_write_n_i | (~lane_write_en_n_i & ~&lane_sel_n_i);
  always_comb begin
    if (!all_lane_write_n_i) begin
      lane_we = '1;
    end else if (!lane_write_en_n_i) begin
      lane_we = ~lane_sel_n_i;
    end else begin
      lane_we = '0;
    end
  end
  assign desel = load & ~sel;
  assign cont = awake & ~load & active_q;
  assign step = cont & ~burst_step_n_i;
  always_comb begin
    op = OP_IDLE;
    if (load && sel) begin
      // processor strobe always opens with a read
      op = (strobe_p || !wr_any) ? OP_READ : OP_WRITE;
    end else if (cont) begin
      op = wr_any ? OP_WRITE : OP_READ;
    end
  end
  assign rd = (op == OP_READ);
  assign wr = (op == OP_WRITE);

  // ************************************************************
  // burst address
  // ************************************************************
  assign cur_cnt = step ? BURST_W'(cnt_q + 1'b1) : cnt_q;
  assign acc_base = load ? addr_i[1:0] : base_q;
  assign acc_cnt = load ? '0 : cur_cnt;
  always_comb begin
    if (ctrl_q[CTRL_ORDER_BIT]) begin
      acc_low = acc_base ^ acc_cnt;
    end else begin
      acc_low = BURST_W'(acc_base + acc_cnt);
    end
  end
  assign acc_addr = {(load ? addr_i[AW-1:2] : hi_q), acc_low};

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      hi_q <= '0;
      base_q <= '0;
      cnt_q <= '0;
      active_q <= 1'b0;
    end else if (load) begin
      hi_q <= addr_i[AW-1:2];
      base_q <= addr_i[1:0];
      cnt_q <= '0;
      active_q <= sel;
    end else if (awake) begin
      cnt_q <= cur_cnt;
    end
  end

  // ************************************************************
  // array and read path
  // ************************************************************
  // single-edge write: nothing for the controller to time
  assign mem_we = wr ? lane_we : '0;

  sram_array #(.AW(AW), .LN(LN), .LW(LW)) u_array (
    .clk_i(mclk_i),
    .rd_en_i(rd),
    .addr_i(acc_addr),
    .we_i(mem_we),
    .wdata_i(dq_i),
    .rdata_o(rdata)
  );

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rd1_q <= 1'b0;
      pipe_q <= '0;
    end else begin
      rd1_q <= rd;
      if (rd1_q) begin
        pipe_q <= rdata;
      end
    end
  end

  // deselect cuts the pipeline one stage early
  always_comb begin
    if (flowthru) begin
      drive_d = rd;
    end else begin
      drive_d = rd1_q & ~desel & ~wr & awake;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      drive_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      drive_q <= drive_d;
      sleep_q <= sleep_req_i;
    end
  end

  // muxed and gated after the flops: enable and sleep must act unclocked
  assign dq_o = flowthru ? rdata : pipe_q;
  assign dq_oe_o = drive_q & ~out_en_n_i & ~sleep_req_i;

  // ************************************************************
  // register bus
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      ctrl_q <= CTRL_RST;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr_q <= s_axi_awaddr_i;
        aw_got_q <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
        w_got_q <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid_o) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        if (aw_addr_q == CTRL_OFS) begin
          s_axi_bresp_o <= RESP_OKAY;
          if (w_strb_q[0]) begin
            ctrl_q <= w_data_q[1:0];
          end
        end else if (aw_addr_q == STAT_OFS) begin
          s_axi_bresp_o <= RESP_OKAY;
        end else begin
          s_axi_bresp_o <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
      if (s_axi_araddr_i == CTRL_OFS) begin
        s_axi_rdata_o[1:0] <= ctrl_q;
      end else if (s_axi_araddr_i == STAT_OFS) begin
        s_axi_rdata_o[STAT_CNT_LSB +: BURST_W] <= cnt_q;
        s_axi_rdata_o[STAT_ACTIVE_BIT] <= active_q;
        s_axi_rdata_o[STAT_SLEEP_BIT] <= sleep_q;
        s_axi_rdata_o[STAT_DRIVE_BIT] <= drive_q;
      end else begin
        s_axi_rresp_o <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_four_steps;
    step [*4];
  endsequence
  sequence s_pipe_read;
    rd && !flowthru;
  endsequence

  property p_load_clears;
    load |=> (cnt_q == '0) && (base_q == $past(addr_i[1:0]));
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("load missed");
  property p_step;
    step |=> cnt_q == BURST_W'($past(cnt_q) + 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");
  property p_hold;
    (cont && burst_step_n_i) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved");
  property p_wrap;
    s_four_steps |=> cnt_q == $past(cnt_q, 4);
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst did not wrap");
  property p_flow_oe;
    (rd && flowthru) |=> drive_q;
  endproperty
  a_flow_oe: assert property (p_flow_oe) else $error("flow read not driven");
  property p_pipe_oe;
    s_pipe_read ##1 (!desel && !wr && awake && !flowthru) |=> drive_q && pipe_q == $past(rdata);
  endproperty
  a_pipe_oe: assert property (p_pipe_oe) else $error("pipeline read lost");
  property p_desel_off;
    (desel && !flowthru) |=> !drive_q;
  endproperty
  a_desel_off: assert property (p_desel_off) else $error("deselect kept drive");
  property p_all_lanes;
    (wr && !all_lane_write_n_i) |-> mem_we == '1;
  endproperty
  a_all_lanes: assert property (p_all_lanes) else $error("global write partial");
  property p_sleep;
    sleep_req_i |=> !rd1_q && !dq_oe_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("activity in sleep");
  property p_unsel;
    (load && !sel) |=> !active_q;
  endproperty
  a_unsel: assert property (p_unsel) else $error("selected wrongly");
  property p_lane_gate;
    (wr && all_lane_write_n_i) |-> mem_we == ~lane_sel_n_i;
  endproperty
  a_lane_gate: assert property (p_lane_gate) else $error("lane write leaked");
  property p_load_addr;
    (load && sel) |-> acc_addr == addr_i;
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("new address lost");
  // a pipeline-mode read followed by deselect must never reach the pins
  sequence s_read_then_desel;
    rd && !flowthru ##1 desel;
  endsequence
  property p_single_cut;
    s_read_then_desel |=> !drive_q;
  endproperty
  a_single_cut: assert property (p_single_cut) else $error("read passed deselect");
endmodule // sync_burst_sram

//--- rtl/sram_pkg.sv
package sram_pkg;
  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int ARRAY_BITS = 9437184;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int ADDR_W = $clog2(ARRAY_BITS / DATA_W);
  localparam int BURST_W = 2;
  // ************************************************************
  // register bus
  // ************************************************************
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] STAT_OFS = 8'h04;
  localparam int CTRL_ORDER_BIT = 0;
  localparam int CTRL_FLOW_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_ACTIVE_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_DRIVE_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_type;
endpackage

//--- rtl/sram_array.sv
module sram_array #(
  parameter int AW = 18,
  parameter int LN = 4,
  parameter int LW = 9
) (
  input wire logic clk_i,
  input wire logic rd_en_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [LN-1:0] we_i,
  input wire logic [LN*LW-1:0] wdata_i,
  output logic [LN*LW-1:0] rdata_o
);
  // ************************************************************
  // one storage column per byte lane
  // ************************************************************
  for (genvar g = 0; g < LN; g++) begin : g_lane
    logic [LW-1:0] mem [2**AW];
    always_ff @(posedge clk_i) begin
      if (we_i[g]) begin
        mem[addr_i] <= wdata_i[g*LW +: LW];
      end
      if (rd_en_i) begin
        rdata_o[g*LW +: LW] <= mem[addr_i];
      end
    end
  end
endmodule // sram_array

//--- tb/ctrl_model.sv
module ctrl_model
  import sram_pkg::*;
(
  input wire logic mclk_i,
  output logic sel_n_o,
  output logic sel_hi_o,
  output logic sel_aux_n_o,
  output logic proc_n_o,
  output logic ctl_n_o,
  output logic step_n_o,
  output logic bw_n_o,
  output logic gw_n_o,
  output logic [LANES-1:0] lane_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_n_o = 1'b1;
    sel_hi_o = 1'b1;
    sel_aux_n_o = 1'b0;
    proc_n_o = 1'b1;
    ctl_n_o = 1'b1;
    step_n_o = 1'b1;
    bw_n_o = 1'b1;
    gw_n_o = 1'b1;
    lane_n_o = '1;
    addr_o = '0;
    dq_o = '0;
  end
  // ****************************************
  // one bus cycle per call
  // ****************************************
  // 0 idle, 1 advance, 2/7 read by either strobe, 3 global write,
  // 4 lane write, 5 deselect, 6 deselect by processor strobe with high enable off
  task automatic cyc(input int k, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [LANES-1:0] l);
    @(posedge mclk_i);
    sel_n_o <= (k == 5);
    sel_hi_o <= (k != 6);
    proc_n_o <= !(k == 2 || k == 6);
    ctl_n_o <= !(k == 3 || k == 4 || k == 5 || k == 7);
    step_n_o <= !(k == 1);
    bw_n_o <= !(k == 3 || k == 4);
    gw_n_o <= !(k == 3);
    lane_n_o <= ~l;
    addr_o <= a;
    // released data bus flips so stale values never look valid
    dq_o <= (k == 3 || k == 4) ? d : ~dq_o;
  endtask
endmodule // ctrl_model

//--- tb/testbench.sv
module testbench;
  import sram_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, nrst_i, oe_n, slp, sel_n, sel_hi, aux_n, prc_n, ctl_n, stp_n, bw_n, gw_n;
  logic [LANES-1:0] ln_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dqi, dqo, d;
  logic dq_oe, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] shadow [16];
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h0000_6c93;
  int b;
  ctrl_model u_ctl (.mclk_i(mclk_i), .sel_n_o(sel_n), .sel_hi_o(sel_hi),
    .sel_aux_n_o(aux_n), .proc_n_o(prc_n), .ctl_n_o(ctl_n), .step_n_o(stp_n),
    .bw_n_o(bw_n), .gw_n_o(gw_n), .lane_n_o(ln_n), .addr_o(addr), .dq_o(dqi));
  sync_burst_sram u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .chip_sel_n_i(sel_n),
    .chip_sel_hi_i(sel_hi), .chip_sel_aux_n_i(aux_n), .proc_addr_strobe_n_i(prc_n),
    .ctrl_addr_strobe_n_i(ctl_n), .burst_step_n_i(stp_n), .lane_write_en_n_i(bw_n),
    .all_lane_write_n_i(gw_n), .lane_sel_n_i(ln_n), .addr_i(addr), .dq_i(dqi),
    .dq_o(dqo), .dq_oe_o(dq_oe), .out_en_n_i(oe_n), .sleep_req_i(slp),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'({$random(seed), $random(seed)});
  endfunction
  function automatic logic [ADDR_W-1:0] ad(int i);
    return 18'h0_1230 + ADDR_W'(i);
  endfunction
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, n, logic [LANES-1:0] l);
    for (int j = 0; j < LANES; j++) begin
      if (l[j]) o[j*LANE_W +: LANE_W] = n[j*LANE_W +: LANE_W];
    end
    return o;
  endfunction
  function automatic int nxt(bit o, int s, int k);
    return o ? ((s ^ k) & 3) : ((s + k) & 3);
  endfunction
  task automatic tally(input bit bad, input string what);
    checks_done++;
    if (bad) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    tally(g !== e, $sformatf("data got %h want %h", g, e));
  endtask
  task automatic chk_oe(input logic g, input logic e);
    tally(g !== e, $sformatf("drive got %b want %b", g, e));
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    tally(g !== e, $sformatf("word got %h want %h", g, e));
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    tally(g !== e, $sformatf("resp got %h want %h", g, e));
  endtask
  task automatic close_out;
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // register bus master
  // ****************************************
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_resp(bresp, r);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk_word(rdata, v);
    chk_resp(rresp, r);
  endtask
  // deselect, read, then check latency and async enable
  task automatic rdc(input int i, input bit p);
    u_ctl.cyc(5, ad(i), '0, '0);
    u_ctl.cyc(i % 2 ? 7 : 2, ad(i), '0, '0);
    #1 chk_oe(dq_oe, 1'b0);
    u_ctl.cyc(0, ad(i), '0, '0);
    if (p) begin
      #1 chk_oe(dq_oe, 1'b0);
      u_ctl.cyc(0, ad(i), '0, '0);
    end
    #1 chk_oe(dq_oe, 1'b1);
    chk(dqo, shadow[i]);
    oe_n <= 1'b1;
    #1 chk_oe(dq_oe, 1'b0);
    oe_n <= 1'b0;
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    close_out;
  end
  initial begin
    {nrst_i, oe_n, slp, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    axr(CTRL_OFS, 32'h0000_0002, RESP_OKAY);
    axr(8'h08, 32'h0000_0000, RESP_SLVERR);
    axw(8'h0c, 32'h0000_0001, RESP_SLVERR);
    for (int i = 0; i < 16; i++) begin
      shadow[i] = rnd();
      u_ctl.cyc(3, ad(i), shadow[i], 4'($random(seed)));
    end
    for (int i = 0; i < 16; i += 2) begin
      d = rnd();
      b = $random(seed);
      shadow[i] = merge(shadow[i], d, 4'(b));
      u_ctl.cyc(4, ad(i), d, 4'(b));
    end
    // let the last lane write land before sleep blocks it
    u_ctl.cyc(0, ad(1), '0, '0);
    slp <= 1'b1;
    u_ctl.cyc(3, ad(1), ~shadow[1], '0);
    u_ctl.cyc(0, ad(1), '0, '0);
    #1 chk_oe(dq_oe, 1'b0);
    axr(STAT_OFS, 32'h0000_000c, RESP_OKAY);
    slp <= 1'b0;
    // flow first, pipeline after, one deselect per read
    for (int m = 0; m < 2; m++) begin
      axw(CTRL_OFS, m ? 32'h0000_0002 : 32'h0000_0000, RESP_OKAY);
      for (int i = 0; i < 16; i++) rdc(i, m[0]);
    end
    // bursts in flow mode, both orders, random start
    for (int o = 0; o < 2; o++) begin
      axw(CTRL_OFS, 32'(o), RESP_OKAY);
      b = $random(seed) & 3;
      u_ctl.cyc(6, ad(b), '0, '0);
      u_ctl.cyc(2, ad(b), '0, '0);
      #1 chk_oe(dq_oe, 1'b0);
      u_ctl.cyc(0, ad(b), '0, '0);
      #1 chk(dqo, shadow[b]);
      // advance shows its address one edge after it is driven
      for (int k = 1; k < 5; k++) begin
        u_ctl.cyc(1, ad(b), '0, '0);
        #1 chk(dqo, shadow[nxt(o[0], b, k - 1)]);
        u_ctl.cyc(0, ad(b), '0, '0);
        #1 chk(dqo, shadow[nxt(o[0], b, k)]);
      end
      // four advances back to back wrap to the start
      for (int k = 1; k < 5; k++) begin
        u_ctl.cyc(1, ad(b), '0, '0);
        #1 chk(dqo, shadow[nxt(o[0], b, k - 1)]);
      end
      u_ctl.cyc(0, ad(b), '0, '0);
      #1 chk(dqo, shadow[b]);
    end
    axr(STAT_OFS, 32'h0000_0014, RESP_OKAY);
    close_out;
  end
endmodule // testbench
